/* File: hw/devctl_params.svh */
// Offsets, field positions, reset values of the device control/status pair
`ifndef DEVCTL_PARAMS_SVH
`define DEVCTL_PARAMS_SVH

`define DEV_CONTROL_OFFSET 8'h98
`define DEV_STATUS_OFFSET 8'h9A

`define CTL_CORR_EN_BIT 0
`define CTL_NONFATAL_EN_BIT 1
`define CTL_FATAL_EN_BIT 2
`define CTL_UNSUP_EN_BIT 3
`define CTL_PAYLOAD_LSB 5
`define CTL_PAYLOAD_MSB 7

`define STS_CORR_BIT 0
`define STS_NONFATAL_BIT 1
`define STS_FATAL_BIT 2
`define STS_UNSUP_BIT 3
`define STS_AUX_BIT 4
`define STS_OUTSTANDING_BIT 5

`define PAYLOAD_RESET 3'h0
`define ENABLES_RESET 4'h0
`define FLAGS_RESET 4'h0

`endif

/* File: hw/devctl_pkg.sv */
// Types shared by the device control/status register pair
package devctl_pkg;

	typedef struct packed {
		logic unsupported_request;
		logic fatal;
		logic nonfatal;
		logic correctable;
	} err_events_s;

	typedef struct packed {
		logic unsupported_request;
		logic fatal;
		logic nonfatal;
		logic correctable;
	} err_msgs_s;

	typedef struct packed {
		logic [7:0] addr;
		logic [15:0] wdata;
		logic [1:0] byte_en;
		logic wr;
		logic rd;
	} cfg_req_s;

endpackage

/* File: hw/pcie_device_ctrl_status_regs.sv */
// Device control and device status registers of a downstream switch port
//
// Behaviour
// - Control bit 9 phantom function enable reads zero, writes ignored.
// - Control bit 8 extended tag enable reads zero, writes ignored.
// - Control bits 7:5 writable max payload size, reset 000.
// - Control bit 4 relaxed ordering enable reads zero.
// - Bit 3 set: unsupported request sends unsupported request message; clear: none.
// - Bit 2 set: fatal error event sends fatal message; clear: none.
// - Bit 1 set: nonfatal error event sends nonfatal message; clear: none.
// - Bit 0 set: correctable error event sends correctable message; clear: none.
// - Status bits 15:6 always read zero.
// - Status bit 5 shows an outstanding non-posted transaction.
// - Status bit 4 mirrors the global aux power present bit.
// - Status bit 3 set when an unsupported request is detected.
// - Status bit 2 set when a fatal error is detected.
// - Status bit 1 set when a nonfatal error is detected.
// - Status bit 0 set when a correctable error is detected.
// - Error flags record events regardless of reporting enables.
// - Error flags clear only by writing one; zero leaves them.
`include "devctl_params.svh"

module pcie_device_ctrl_status_regs
	import devctl_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Configuration access
	input wire cfg_req_s cfg_req,
	output logic [15:0] cfg_rdata,
	output logic cfg_rvalid,
	// Port state
	input wire err_events_s err_events,
	input wire logic outstanding_request,
	input wire logic global_aux_power_present,
	// Error messages toward the root complex, high for one cycle per cycle of an enabled event
	output err_msgs_s err_msgs,
	// Control fields to the port
	output logic [2:0] max_payload_size
);

	////////////////////////////////////////////////////////////////////////
	// Address decode

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a[7:1] == off[7:1]);
	endfunction

	logic ctl_wr;
	logic sts_wr;
	logic lo_en;

	always_comb begin
		ctl_wr = cfg_req.wr && hit(cfg_req.addr, `DEV_CONTROL_OFFSET);
		sts_wr = cfg_req.wr && hit(cfg_req.addr, `DEV_STATUS_OFFSET);
		lo_en = cfg_req.byte_en[0];
	end

	////////////////////////////////////////////////////////////////////////
	// Control register

	logic [2:0] payload_r;
	logic [2:0] payload_nxt;
	logic [3:0] enables_r;
	logic [3:0] enables_nxt;

	always_comb begin
		payload_nxt = payload_r;
		enables_nxt = enables_r;
		// Bits 9, 8 and 4 have no storage, so writes to them vanish
		if (ctl_wr && lo_en) begin
			// Reserved codes 110/111 stored as written; port logic must clamp
			payload_nxt = cfg_req.wdata[`CTL_PAYLOAD_MSB:`CTL_PAYLOAD_LSB];
			enables_nxt = cfg_req.wdata[`CTL_UNSUP_EN_BIT:`CTL_CORR_EN_BIT];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			payload_r <= `PAYLOAD_RESET;
			enables_r <= `ENABLES_RESET;
		end else begin
			payload_r <= payload_nxt;
			enables_r <= enables_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status flags and message generation

	logic [3:0] flags_r;
	logic [3:0] flags_nxt;
	logic [3:0] ev;
	logic [3:0] clr;
	err_msgs_s msgs_r;
	err_msgs_s msgs_nxt;
	logic [2:0] payload_out_r;

	always_comb begin
		ev = {err_events.unsupported_request, err_events.fatal,
			err_events.nonfatal, err_events.correctable};
		clr = (sts_wr && lo_en) ? cfg_req.wdata[`STS_UNSUP_BIT:`STS_CORR_BIT] : 4'h0;
		// Set wins over a simultaneous write-one clear
		flags_nxt = (flags_r & ~clr) | ev;
		msgs_nxt.unsupported_request = err_events.unsupported_request && enables_r[`CTL_UNSUP_EN_BIT];
		msgs_nxt.fatal = err_events.fatal && enables_r[`CTL_FATAL_EN_BIT];
		msgs_nxt.nonfatal = err_events.nonfatal && enables_r[`CTL_NONFATAL_EN_BIT];
		msgs_nxt.correctable = err_events.correctable && enables_r[`CTL_CORR_EN_BIT];
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flags_r <= `FLAGS_RESET;
			msgs_r <= '0;
			payload_out_r <= `PAYLOAD_RESET;
		end else begin
			flags_r <= flags_nxt;
			msgs_r <= msgs_nxt;
			payload_out_r <= payload_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data

	logic [15:0] rdata_nxt;
	logic [15:0] rdata_r;
	logic rvalid_r;

	always_comb begin
		rdata_nxt = 16'h0000;
		if (cfg_req.rd && hit(cfg_req.addr, `DEV_CONTROL_OFFSET)) begin
			rdata_nxt[`CTL_PAYLOAD_MSB:`CTL_PAYLOAD_LSB] = payload_r;
			rdata_nxt[`CTL_UNSUP_EN_BIT:`CTL_CORR_EN_BIT] = enables_r;
		end else if (cfg_req.rd && hit(cfg_req.addr, `DEV_STATUS_OFFSET)) begin
			// Live same-clock levels, so the mirror holds from reset on
			rdata_nxt[`STS_OUTSTANDING_BIT] = outstanding_request;
			rdata_nxt[`STS_AUX_BIT] = global_aux_power_present;
			rdata_nxt[`STS_UNSUP_BIT:`STS_CORR_BIT] = flags_r;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= 16'h0000;
			rvalid_r <= 1'b0;
		end else begin
			rdata_r <= rdata_nxt;
			rvalid_r <= cfg_req.rd;
		end
	end

	assign cfg_rdata = rdata_r;
	assign cfg_rvalid = rvalid_r;
	assign err_msgs = msgs_r;
	assign max_payload_size = payload_out_r;

endmodule

/* File: tb/devctl_monitor.sv */
// Port checks on the device control/status pair
module devctl_monitor import devctl_pkg::*;(
	// Design ports
	input wire logic clk,
	input wire logic rst_n,
	input wire cfg_req_s cfg_req,
	input wire logic [15:0] cfg_rdata,
	input wire logic cfg_rvalid,
	input wire err_events_s err_events,
	input wire logic outstanding_request,
	input wire logic global_aux_power_present,
	input wire err_msgs_s err_msgs,
	input wire logic [2:0] max_payload_size
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] a_r;
	always_ff @(posedge clk) a_r <= cfg_req.addr;
	wire ctl = cfg_rvalid && a_r[7:1] == 7'h4C;
	wire sts = cfg_rvalid && a_r[7:1] == 7'h4D;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	chk_ctl_ro: assert property (ctl |-> cfg_rdata[9:8] == 2'h0)
		else $error("ctl 9:8");
	chk_ctl_relaxed: assert property (ctl |-> !cfg_rdata[4])
		else $error("ctl 4");
	chk_ctl_payload: assert property (ctl |-> cfg_rdata[7:5] == $past(max_payload_size))
		else $error("payload read");
	chk_payload_hold: assert property (!$past(cfg_req.wr) |-> $stable(max_payload_size))
		else $error("payload moved");
	chk_sts_rsvd: assert property (sts |-> cfg_rdata[15:6] == 10'h0)
		else $error("sts rsvd");
	chk_sts_aux: assert property (sts |-> cfg_rdata[4] == $past(global_aux_power_present))
		else $error("aux");
	chk_sts_outstanding: assert property (sts |-> cfg_rdata[5] == $past(outstanding_request))
		else $error("outstanding");
	chk_msg_cause: assert property (|err_msgs |-> (err_msgs & ~$past(err_events)) == 4'h0)
		else $error("msg cause");
	chk_unmapped_zero: assert property (cfg_rvalid && !ctl && !sts |-> cfg_rdata == 16'h0000)
		else $error("unmapped read");
	cover property (sts && cfg_rdata[3:0] == 4'hF);
	cover property (err_msgs.fatal);
	cover property (ctl && max_payload_size == 3'h5);
	cover property (cfg_rvalid && !ctl && !sts);
endmodule
bind pcie_device_ctrl_status_regs devctl_monitor u_devctl_monitor (.*);

/* File: tb/rc_model.sv */
// Root complex side: counts arriving error messages
module rc_model import devctl_pkg::*;(
	// Message sink
	input wire logic clk,
	input wire err_msgs_s err_msgs,
	output logic [7:0] n_msg
);
	timeunit 1ns;
	timeprecision 1ps;
	initial n_msg = 8'h00;
	always @(posedge clk) n_msg <= n_msg + 8'($countones(err_msgs));
endmodule

/* File: tb/pcie_device_ctrl_status_regs_tb.sv */
// Self-checking bench for the device control/status pair
module pcie_device_ctrl_status_regs_tb import devctl_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst_n = 0, aux = 1, outstanding = 0, rvalid;
	cfg_req_s req = '0;
	err_events_s ev = '0;
	err_msgs_s msgs;
	logic [15:0] rdata, q[$];
	logic [2:0] payload;
	logic [7:0] n_msg;
	logic [3:0] en, cl;
	int bad_count = 0, compares = 0, n_exp = 0;
	pcie_device_ctrl_status_regs u_pcie_device_ctrl_status_regs (.clk, .rst_n, .cfg_req(req),
		.cfg_rdata(rdata), .cfg_rvalid(rvalid), .err_events(ev), .outstanding_request(outstanding),
		.global_aux_power_present(aux), .err_msgs(msgs), .max_payload_size(payload));
	rc_model u_rc_model (.clk, .err_msgs(msgs), .n_msg);
	initial forever #2.5 clk = ~clk;
	////////////////////////////////////////////////////////////////
	task automatic chk(string s, logic [15:0] e, logic [15:0] g);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s exp %h got %h", s, e, g);
		end
	endtask
	// Reads note the expected word; the watcher below compares it
	task automatic acc(logic [7:0] a, logic [15:0] d, logic w, logic [1:0] be = 2'h1);
		@(negedge clk);
		req <= '{a, d, be, w, !w};
		if (!w)
			q.push_back(d);
		@(negedge clk);
		req <= '0;
	endtask
	task automatic print_verdict;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(negedge clk)
		if (rvalid === 1'b1)
			chk("rdata", q.pop_front(), rdata);
	initial begin
		void'($urandom(32'h6acf));
		repeat (16) @(posedge clk);
		@(negedge clk) rst_n <= 1;
		acc(8'h98, 16'h0000, 0);
		acc(8'h9A, 16'h0010, 0);
		acc(8'h98, 16'hFFFF, 1);
		acc(8'h98, 16'h00EF, 0);
		acc(8'h98, 16'h0000, 1, 2'h2);
		acc(8'h98, 16'h00EF, 0);
		for (int i = 0; i < 8; i++) begin
			acc(8'h98, 16'(i << 5), 1);
			chk("payload", 16'(i), {13'h0, payload});
		end
		en = 4'($urandom);
		acc(8'h98, {12'h0, en}, 1);
		outstanding <= 1;
		// Back-to-back events, one kind per cycle
		for (int k = 0; k < 4; k++) begin
			@(negedge clk) ev <= err_events_s'(4'h1 << k);
			n_exp += en[k];
		end
		@(negedge clk) ev <= '0;
		// Opposite enables and all four events at once, so every enable is seen both ways
		acc(8'h98, {12'h0, ~en}, 1);
		@(negedge clk) ev <= '1;
		n_exp += 4 - $countones(en);
		@(negedge clk) ev <= '0;
		acc(8'h9A, 16'h003F, 0);
		acc(8'h9A, 16'h0000, 1);
		acc(8'h9A, 16'h003F, 0);
		cl = 4'($urandom);
		aux <= 0;
		outstanding <= 0;
		acc(8'h9A, {12'hFFF, cl}, 1);
		acc(8'h9A, {12'h0, ~cl}, 0);
		acc(8'h40, 16'h0000, 0);
		repeat (2) @(negedge clk);
		chk("msgs", 16'(n_exp), {8'h0, n_msg});
		// Mid-run reset must restore every reset value
		@(negedge clk) rst_n <= 0;
		repeat (4) @(negedge clk);
		rst_n <= 1;
		acc(8'h98, 16'h0000, 0);
		acc(8'h9A, 16'h0000, 0);
		// Let the watcher take the last read before counting what is left
		repeat (2) @(negedge clk);
		chk("left", 16'h0, 16'(q.size()));
		print_verdict();
	end
endmodule
